/* verilog/afmt_pkg.sv */
/*
  Constants for the converter result formatter: register offsets, field
  positions, reset values and widths.
  Assumes an APB bus with 32-bit data, one register per aligned word.
*/
package afmt_pkg;

  // Data widths
  localparam int unsigned RES_W  = 10;
  localparam int unsigned REG_W  = 8;
  localparam int unsigned ADDR_W = 12;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CONTROL_0   = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_CONTROL_1   = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_ANALOG_SEL  = 12'h008;
  localparam logic [ADDR_W-1:0] OFS_RESULT_HIGH = 12'h00c;
  localparam logic [ADDR_W-1:0] OFS_RESULT_LOW  = 12'h010;

  // Field positions and masks
  localparam int unsigned      JUSTIFY_BIT    = 7;
  localparam logic [REG_W-1:0] CONTROL_1_MASK = 8'h70;

  // Reset values
  localparam logic [REG_W-1:0] RST_CONTROL_0  = 8'h00;
  localparam logic [REG_W-1:0] RST_CONTROL_1  = 8'h00;
  localparam logic [REG_W-1:0] RST_ANALOG_SEL = 8'hff;

  // Control-side state, set back to its reset values by every reset
  typedef struct packed {
    logic [REG_W-1:0] control_0;
    logic [REG_W-1:0] control_1;
    logic [REG_W-1:0] analog_sel;
    logic             pready;
    logic             pslverr;
    logic [31:0]      prdata;
  } afmt_ctrl_s;

  // Result registers, never touched by the device resets
  typedef struct packed {
    logic [REG_W-1:0] result_high;
    logic [REG_W-1:0] result_low;
  } afmt_res_s;

endpackage : afmt_pkg

/* verilog/afmt_result_formatter.sv */
/*
  Result formatter of a 10-bit converter: APB register slave holding the
  control registers and the high and low result registers, and the logic
  that justifies each finished conversion into the two result bytes.
  Assumes the converter runs on pclk and pulses conv_done for one cycle with
  conv_data valid in that cycle; the APB master keeps the APB protocol.
  Assumes presetn is the only reset that arrives here; the result registers
  have no reset input at all, so power-up leaves them unknown and every
  later reset leaves them as they were. Sequencing, channel selection and
  the conversion itself live outside this block.
*/
// Our own choices: the address map and the APB slave port.
`timescale 1ns/100ps

// Notes on behaviour
// - Left justified: result bits 9..2 go to result_high bits 7..0.
// - Left justified: result bits 1..0 go to result_low 7..6; rest reserved.
// - Right justified: result bits 9..8 go to result_high bits 1..0.
// - Right justified: result bits 7..0 go to result_low bits 7..0.
// - Result registers unknown after power-up, untouched by later resets.
module afmt_result_formatter
  import afmt_pkg::*;
(
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [ADDR_W-1:0]  paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic               conv_done,
  input  wire logic [RES_W-1:0]   conv_data,
  output logic      [REG_W-1:0]   adc_control_0,
  output logic      [REG_W-1:0]   adc_control_1,
  output logic      [REG_W-1:0]   analog_select,
  output logic                    justify_select
);

  // Registered state; results sit apart because presetn never reaches them
  afmt_ctrl_s       ctrl;
  afmt_ctrl_s       next_ctrl;
  afmt_res_s        res;
  afmt_res_s        next_res;

  // Bus phase qualifiers
  logic             setup;
  logic             access;
  logic             wr_take;

  // Address decode, one hit per mapped register
  logic             hit_control_0;
  logic             hit_control_1;
  logic             hit_analog_sel;
  logic             hit_result_high;
  logic             hit_result_low;
  logic             rd_hit;

  // Write strobes, each high only on the edge that ends a write
  logic             wr_control_0;
  logic             wr_control_1;
  logic             wr_analog_sel;
  logic             wr_result_high;
  logic             wr_result_low;

  // Conversion side, and the read answer
  logic             load_result;
  logic             justify_now;
  logic [REG_W-1:0] fmt_high;
  logic [REG_W-1:0] fmt_low;
  logic [REG_W-1:0] rd_byte;
  logic [31:0]      rd_word;

  // Setup phase starts the one-cycle answer, so the access phase is
  // always a single cycle and a write lands on the edge that ends it
  assign setup   = psel & ~penable;
  assign access  = psel & penable & ctrl.pready;
  assign wr_take = access & pwrite;

  // Address decode on the full address, so no word answers at an alias;
  // an unmapped word hits nothing
  always_comb begin
    hit_control_0   = 1'b0;
    hit_control_1   = 1'b0;
    hit_analog_sel  = 1'b0;
    hit_result_high = 1'b0;
    hit_result_low  = 1'b0;
    if (paddr == OFS_CONTROL_0) begin
      hit_control_0 = 1'b1;
    end else if (paddr == OFS_CONTROL_1) begin
      hit_control_1 = 1'b1;
    end else if (paddr == OFS_ANALOG_SEL) begin
      hit_analog_sel = 1'b1;
    end else if (paddr == OFS_RESULT_HIGH) begin
      hit_result_high = 1'b1;
    end else if (paddr == OFS_RESULT_LOW) begin
      hit_result_low = 1'b1;
    end
  end

  // Any hit makes the address legal; a miss answers with an error
  assign rd_hit = hit_control_0 | hit_control_1 | hit_analog_sel
                | hit_result_high | hit_result_low;

  // Write strobes; a write to an unmapped word is dropped
  assign wr_control_0   = wr_take & hit_control_0;
  assign wr_control_1   = wr_take & hit_control_1;
  assign wr_analog_sel  = wr_take & hit_analog_sel;
  assign wr_result_high = wr_take & hit_result_high;
  assign wr_result_low  = wr_take & hit_result_low;

  // A finished conversion loads both result bytes on the same edge
  assign load_result = conv_done;

  // Justification as held before this edge: a control write that lands
  // together with a conversion only steers the next conversion
  assign justify_now = ctrl.control_0[JUSTIFY_BIT];

  // Format the fresh result with the justification in force this cycle
  always_comb begin
    if (justify_now) begin
      fmt_high = {6'h00, conv_data[9:8]};
      fmt_low  = conv_data[7:0];
    end else begin
      fmt_high = conv_data[9:2];
      fmt_low  = {conv_data[1:0], 6'h00};
    end
  end

  // Read mux; selects the byte named by the decode, zero on a miss,
  // so an unmapped read returns zero next to its error flag
  always_comb begin
    rd_byte = 8'h00;
    if (hit_control_0) begin
      rd_byte = ctrl.control_0;
    end else if (hit_control_1) begin
      rd_byte = ctrl.control_1;
    end else if (hit_analog_sel) begin
      rd_byte = ctrl.analog_sel;
    end else if (hit_result_high) begin
      rd_byte = res.result_high;
    end else if (hit_result_low) begin
      rd_byte = res.result_low;
    end
  end

  // One byte per aligned word; the upper bits always read zero
  assign rd_word = {24'h000000, rd_byte};

  // Control state and bus answer; the answer is built in the setup cycle
  // and stands for the access cycle only
  always_comb begin
    next_ctrl         = ctrl;
    next_ctrl.pready  = setup;
    next_ctrl.pslverr = setup & ~rd_hit;
    // Zero outside read answers, so an or of several slaves stays clean
    next_ctrl.prdata  = 32'h00000000;
    if (setup && !pwrite) begin
      next_ctrl.prdata = rd_word;
    end
    if (wr_control_0) begin
      next_ctrl.control_0 = pwdata[REG_W-1:0];
    end
    if (wr_control_1) begin
      // Only bits 6..4 hold state; the other bits read back as zero
      next_ctrl.control_1 = pwdata[REG_W-1:0] & CONTROL_1_MASK;
    end
    if (wr_analog_sel) begin
      next_ctrl.analog_sel = pwdata[REG_W-1:0];
    end
  end

  // Result registers: a completing conversion beats a software write in
  // the same cycle, so in that cycle both bytes come from the conversion
  always_comb begin
    next_res = res;
    if (wr_result_high) begin
      next_res.result_high = pwdata[REG_W-1:0];
    end
    if (wr_result_low) begin
      next_res.result_low = pwdata[REG_W-1:0];
    end
    if (load_result) begin
      next_res.result_high = fmt_high;
      next_res.result_low  = fmt_low;
    end
  end

  // Control flops; every reset brings them back to their defaults
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl.control_0  <= RST_CONTROL_0;
      ctrl.control_1  <= RST_CONTROL_1;
      ctrl.analog_sel <= RST_ANALOG_SEL;
      ctrl.pready     <= 1'b0;
      ctrl.pslverr    <= 1'b0;
      ctrl.prdata     <= 32'h00000000;
    end else begin
      ctrl <= next_ctrl;
    end
  end

  // No reset on purpose: power-up leaves these unknown and a later reset
  // keeps the last conversion for software to read afterwards. Limitation:
  // a read before the first conversion or write returns unknown bits.
  // Kept out of the control struct for exactly that reason.
  always_ff @(posedge pclk) begin
    res <= next_res;
  end

  // Bus answer, straight from its flops
  assign prdata         = ctrl.prdata;
  assign pready         = ctrl.pready;
  assign pslverr        = ctrl.pslverr;

  // Register views; justify_select is one flop of control register 0,
  // so it shows the setting that the next conversion will use
  assign adc_control_0  = ctrl.control_0;
  assign adc_control_1  = ctrl.control_1;
  assign analog_select  = ctrl.analog_sel;
  assign justify_select = ctrl.control_0[JUSTIFY_BIT];

endmodule : afmt_result_formatter

/* verification/afmt_result_formatter_properties.sv */
/*
  Checker of result formatting as seen on APB reads of the result registers.
  Assumes binding to afmt_result_formatter; the shadow has no reset, like the results.
*/
`timescale 1ns/100ps
module afmt_properties
  import afmt_pkg::*;
(
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic              pready,
  input wire logic              conv_done,
  input wire logic              justify_select,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       prdata,
  input wire logic [RES_W-1:0]  conv_data
);
  logic [RES_W-1:0] d;
  logic             m, r, cd;
  logic             v = 1'b0;
  // Shadow of the last conversion; a software write to a result makes it stale.
  // A conversion on the setup edge of a read is not yet in that read's data.
  always @(posedge pclk) begin
    cd <= conv_done;
    if (conv_done) begin
      d <= conv_data;
      m <= justify_select;
      v <= 1'b1;
    end else if (psel && penable && pready && pwrite && paddr >= OFS_RESULT_HIGH) begin
      v <= 1'b0;
    end
  end
  // Set by reset, cleared by the next conversion
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) r <= 1'b1;
    else if (conv_done) r <= 1'b0;
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire rd_ok = v && !cd && psel && penable && pready && !pwrite;
  wire rh    = rd_ok && paddr == OFS_RESULT_HIGH;
  wire rl    = rd_ok && paddr == OFS_RESULT_LOW;
  sequence s_right_low;
    rl ##0 m;
  endsequence
  AST_LEFT_HIGH: assert property (rh && !m |-> prdata[7:0] == d[9:2])
    else $error("left high byte wrong");
  AST_LEFT_LOW: assert property (rl && !m |-> prdata[7:6] == d[1:0])
    else $error("left low bits wrong");
  AST_RIGHT_HIGH: assert property (rh && m |-> prdata[1:0] == d[9:8])
    else $error("right high bits wrong");
  AST_RIGHT_LOW: assert property (s_right_low |-> prdata[7:0] == d[7:0])
    else $error("right low byte wrong");
  AST_KEEP_OVER_RESET: assert property (rh && r |-> prdata[7:0] == (m ? {6'h0, d[9:8]} : d[9:2]))
    else $error("result lost over reset");
  AST_FORMAT_AT_DONE: assert property (rl && m && !justify_select |-> prdata[7:0] == d[7:0])
    else $error("result reformatted without conversion");
endmodule : afmt_properties

bind afmt_result_formatter afmt_properties u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pready(pready), .conv_done(conv_done),
  .justify_select(justify_select), .paddr(paddr), .prdata(prdata), .conv_data(conv_data));

/* verification/adc_result_formatter_bench.sv */
/*
  Bench for the result formatter: APB tasks, an integer model, LFSR results.
  Assumes the checker is bound from its own file.
*/
`timescale 1ns/100ps
module adc_result_formatter_bench;
  import afmt_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, conv_done = 0;
  logic pready, pslverr, er, js;
  logic [REG_W-1:0]  c0, c1, asel;
  logic [ADDR_W-1:0] paddr = '0;
  logic [RES_W-1:0]  conv_data = '0;
  logic [31:0]       pwdata = '0, prdata, rd;
  int fail_count = 0, checks = 0, cyc = 0, lf = 7, mj = 0, eh = 0, el = 0;
  always #20 pclk = ~pclk;
  afmt_result_formatter dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .conv_done(conv_done), .conv_data(conv_data), .adc_control_0(c0),
    .adc_control_1(c1), .analog_select(asel), .justify_select(js));
  task automatic test_done();
    $display("checks %0d errors %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : test_done
  task automatic chk(string n, logic [31:0] e, logic [31:0] s);
    checks++;
    if (s !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // One APB transfer; request held until pready is sampled high
  task automatic apb(logic w, logic [ADDR_W-1:0] a, logic [31:0] d);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk) penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  // Conversion pulse; the model formats with the justification then in force
  task automatic conv(logic [RES_W-1:0] x);
    conv_done <= 1'b1; conv_data <= x;
    @(posedge pclk) conv_done <= 1'b0;
    eh = mj ? x[9:8] : x[9:2];
    el = mj ? x[7:0] : {x[1:0], 6'h0};
  endtask : conv
  task automatic rchk();
    apb(1'b0, OFS_RESULT_HIGH, 32'h0);
    chk("result_high", eh, rd);
    apb(1'b0, OFS_RESULT_LOW, 32'h0);
    chk("result_low", el, rd);
  endtask : rchk
  // Hang guard: ceiling far above the two hundred or so cycles needed
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 2000) begin
      fail_count++;
      test_done();
    end
  end
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("adc_control_0", 32'h00, c0);
    chk("adc_control_1", 32'h00, c1);
    chk("analog_select_pin", 32'hff, asel);
    apb(1'b0, OFS_ANALOG_SEL, 32'h0);
    chk("analog_select", 32'hff, rd);
    apb(1'b0, 12'h014, 32'h0);
    chk("unmapped_err", 1, er);
    apb(1'b1, 12'h014, 32'hff);
    chk("unmapped_wr_err", 1, er);
    apb(1'b1, OFS_CONTROL_1, 32'hff);
    apb(1'b0, OFS_CONTROL_1, 32'h0);
    chk("control_1", 32'h70, rd);
    chk("adc_control_1", 32'h70, c1);
    apb(1'b1, OFS_ANALOG_SEL, 32'h3c);
    chk("analog_select_pin", 32'h3c, asel);
    apb(1'b1, OFS_RESULT_HIGH, 32'h96);
    apb(1'b0, OFS_RESULT_HIGH, 32'h0);
    chk("result_high_wr", 32'h96, rd);
    for (int i = 0; i < 16; i++) begin
      lf = {lf[8:0], lf[9] ^ lf[6]};
      mj = i % 2;
      apb(1'b1, OFS_CONTROL_0, mj << 7);
      chk("adc_control_0", mj << 7, c0);
      chk("justify_select", mj, js);
      conv(lf[9:0]);
      rchk();
    end
    mj = 0;
    apb(1'b1, OFS_CONTROL_0, 32'h0);
    rchk();
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("justify_select", 0, js);
    chk("adc_control_1", 32'h00, c1);
    chk("analog_select_pin", 32'hff, asel);
    rchk();
    test_done();
  end
endmodule : adc_result_formatter_bench
